/* shared/csa_pkg.sv */
// Constants, carrier types and helpers for the capture address block
package csa_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] CSA_OFS_SUBPIC_CFG = 8'h00;
    localparam logic [7:0] CSA_OFS_LINE_OFS = 8'h04;
    localparam logic [7:0] CSA_OFS_CTRL = 8'h08;
    localparam logic [7:0] CSA_OFS_STATUS = 8'h0c;

    // Field positions of sub_picture_config
    localparam int CSA_HSTART_LSB = 16;
    localparam int CSA_HSTART_MSB = 23;
    localparam int CSA_WIDTH_LSB = 0;
    localparam int CSA_WIDTH_MSB = 8;

    // Field positions of the storage control register
    localparam int CSA_CTRL_SUBPIC = 0;
    localparam int CSA_CTRL_RAW = 1;
    localparam int CSA_CTRL_MUXED = 2;
    localparam int CSA_LINES_LSB = 16;
    localparam int CSA_LINES_MSB = 27;

    // Status bit positions
    localparam int CSA_ST_WIDTH_BAD = 0;
    localparam int CSA_ST_HSTART_BIG = 1;
    localparam int CSA_ST_HSTART_ODD = 2;
    localparam int CSA_ST_OFS_ODD = 3;
    localparam int CSA_ST_BUSY = 4;

    // Reset values
    localparam logic [31:0] CSA_SUBPIC_RST = 32'h0000_0000;
    localparam logic [31:0] CSA_LINE_OFS_RST = 32'h0000_0000;
    localparam logic [31:0] CSA_CTRL_RST = 32'h0000_0000;

    // Low address bits that must be clear (8-byte units)
    localparam int CSA_ALIGN_BITS = 3;

    // Area start addresses from the neighbouring registers
    typedef struct packed {
        logic [31:0] top_luma;
        logic [31:0] bottom_luma;
        logic [31:0] top_chroma;
        logic [31:0] bottom_chroma;
        logic [31:0] top_vanc;
        logic [31:0] bottom_vanc;
    } csa_area_t;

    // One store request from the capture datapath
    typedef struct packed {
        logic bottom;
        logic chroma;
        logic vanc;
        logic [11:0] line;
        logic [11:0] xpos;
    } csa_req_t;

    // Decoded configuration
    typedef struct packed {
        logic subpic;
        logic raw;
        logic muxed;
        logic [7:0] hstart;
        logic [8:0] width;
        logic [11:0] lines;
        logic [31:0] line_ofs;
    } csa_cfg_t;

    // Log2 of a sub-picture width; reserved codes fall back to 16 bytes
    function automatic logic [3:0] csa_width_log2(input logic [8:0] w);
        case (w)
            9'h010: csa_width_log2 = 4'h4;
            9'h020: csa_width_log2 = 4'h5;
            9'h040: csa_width_log2 = 4'h6;
            9'h080: csa_width_log2 = 4'h7;
            9'h100: csa_width_log2 = 4'h8;
            default: csa_width_log2 = 4'h4;
        endcase
    endfunction

    // True for the five legal sub-picture width codes
    function automatic logic csa_width_ok(input logic [8:0] w);
        csa_width_ok = (w == 9'h010) || (w == 9'h020) || (w == 9'h040) ||
            (w == 9'h080) || (w == 9'h100);
    endfunction

endpackage

/* sim/csa_sdram_model.sv */
// Behavioural SDRAM write-port model that logs accepted store addresses
`timescale 1ns/1ns
`default_nettype none
module csa_sdram_model (
    input wire logic clk_i,
    input wire logic rst_ni,
    input wire logic stall_i,
    input wire logic wr_valid_i,
    input wire logic [31:0] wr_addr_i,
    output logic wr_ready_o,
    output logic [7:0] got_cnt_o
);
    logic [31:0] log_q [0:63];
    // Ready follows the stall request one cycle late, like a busy port
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            wr_ready_o <= 1'b0;
            got_cnt_o <= 8'h00;
        end else begin
            wr_ready_o <= !stall_i;
            if (wr_valid_i && wr_ready_o) begin
                log_q[got_cnt_o[5:0]] <= wr_addr_i;
                got_cnt_o <= got_cnt_o + 8'h01;
            end
        end
    end
endmodule // csa_sdram_model
`default_nettype wire

/* sim/csa_top_tb.sv */
// Self-checking bench for the capture store address block
`timescale 1ns/1ns
`default_nettype none
module csa_top_tb;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, req_valid = 1'b0, stall = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, wr_addr, rd;
    logic pready, pslverr, req_ready, wr_valid, wr_ready, er;
    csa_pkg::csa_area_t areas = {32'h1000_0000, 32'h2000_0000,
        32'h3000_0000, 32'h4000_0000, 32'h5000_0000, 32'h6000_0000};
    csa_pkg::csa_req_t req = '0;
    logic [7:0] cnt;
    int miscompares = 0, checks = 0, cycles = 0;
    csa_top uut (.CORE_CLK_I(clk), .RESETN_I(resetn), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .AREA_STARTS_I(areas),
        .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .REQ_I(req),
        .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready), .WR_ADDR_O(wr_addr));
    csa_sdram_model mdl (.clk_i(clk), .rst_ni(resetn), .stall_i(stall),
        .wr_valid_i(wr_valid), .wr_addr_i(wr_addr), .wr_ready_o(wr_ready),
        .got_cnt_o(cnt));
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; waits for pready in the access phase
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One store request; returns the address the SDRAM side took
    task automatic send(input logic b, c, v, input logic [11:0] ln, xp,
            output logic [31:0] got);
        logic [7:0] c0;
        int n;
        c0 = cnt;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= {b, c, v, ln, xp};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        req_valid <= 1'b0;
        n = 0;
        while (cnt == c0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        got = mdl.log_q[c0[5:0]];
    endtask
    // Reset values, field widths, reserved bits, unmapped address
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        check("cfg reset", rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        check("offset reset", rd, 32'h0);
        apb(1'b1, 8'h00, 32'hffff_ffff);
        apb(1'b0, 8'h00, 32'h0);
        check("cfg fields", rd, 32'h00ff_01ff);
        apb(1'b1, 8'h04, 32'hffff_fff8);
        apb(1'b0, 8'h04, 32'h0);
        check("offset rw", rd, 32'hffff_fff8);
        apb(1'b0, 8'h0c, 32'h0);
        check("status flags", rd, 32'h0000_0005);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        check("unmapped data", rd, 32'h0);
        check("ready high", {31'h0, pready}, 32'h1);
    endtask
    // Raster, raw and ancillary line stepping
    task automatic t_raster();
        logic [31:0] g;
        apb(1'b1, 8'h04, 32'h0000_0100);
        apb(1'b1, 8'h00, 32'h0008_0020);
        apb(1'b1, 8'h08, 32'h0004_0000);
        send(1'b0, 1'b0, 1'b0, 12'd3, 12'd8, g);
        check("raster luma", g, 32'h1000_0308);
        apb(1'b1, 8'h08, 32'h0004_0003);
        send(1'b0, 1'b1, 1'b0, 12'd5, 12'd0, g);
        check("raw chroma", g, 32'h3000_0500);
        apb(1'b1, 8'h08, 32'h0000_0004);
        send(1'b0, 1'b0, 1'b1, 12'd2, 12'd8, g);
        check("vanc muxed", g, 32'h5000_0408);
        apb(1'b1, 8'h08, 32'h0000_0000);
        send(1'b1, 1'b0, 1'b1, 12'd2, 12'd8, g);
        check("vanc separate", g, 32'h6000_0208);
    endtask
    // Every width code, two buffers, offset ignored
    task automatic t_subpic();
        int widths [5] = '{16, 32, 64, 128, 256};
        logic [31:0] g, base;
        apb(1'b1, 8'h08, 32'h0004_0001);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h00, {8'h00, 8'h08, 7'h00, 9'(widths[i])});
            for (int j = 0; j < 2; j++) begin
                base = (j == 1) ? 32'h4000_0000 : 32'h1000_0000;
                send(j[0], j[0], 1'b0, 12'd1, 12'(widths[i]), g);
                check("subpic", g, base + 32'(5 * widths[i] + 8));
            end
        end
    endtask
    // Stalled SDRAM port: second request held back, order kept
    task automatic t_stall();
        logic [7:0] c0;
        int n;
        apb(1'b1, 8'h08, 32'h0000_0000);
        c0 = cnt;
        stall <= 1'b1;
        repeat (2) @(posedge clk);
        req_valid <= 1'b1;
        req <= {1'b0, 1'b0, 1'b0, 12'd1, 12'd0};
        @(posedge clk);
        req <= {1'b1, 1'b0, 1'b0, 12'd2, 12'h010};
        repeat (3) @(posedge clk);
        check("ready while full", {31'h0, req_ready}, 32'h0);
        check("valid held", {31'h0, wr_valid}, 32'h1);
        stall <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        req_valid <= 1'b0;
        n = 0;
        while (cnt != c0 + 8'h02 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check("first", mdl.log_q[c0[5:0]], 32'h1000_0100);
        check("second", mdl.log_q[6'(c0 + 8'h01)], 32'h2000_0210);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_raster();
        t_subpic();
        t_stall();
        conclude();
    end
endmodule // csa_top_tb
`default_nettype wire

/* verilog/csa_addr_calc.sv */
// Line and sub-picture store address arithmetic
`timescale 1ns/1ns
`default_nettype none
module csa_addr_calc (
    input wire csa_pkg::csa_cfg_t cfg_i,
    input wire logic [31:0] start_i,
    input wire csa_pkg::csa_req_t req_i,
    output logic [31:0] addr_o
);
    logic [3:0] k;
    logic [12:0] pos;
    logic [31:0] step;
    logic [31:0] raster;
    logic [31:0] tile;
    logic [31:0] col;
    logic [31:0] stride;
    logic [31:0] sub;
    logic use_sub;

    // Sub-picture geometry, start displacement added to byte position
    assign k = csa_pkg::csa_width_log2(cfg_i.width);
    assign pos = {5'h00, cfg_i.hstart} + {1'b0, req_i.xpos};
    // Ancillary lines in muxed mode step by twice the pitch
    assign step = (req_i.vanc && cfg_i.muxed) ?
        {cfg_i.line_ofs[30:0], 1'b0} : cfg_i.line_ofs;
    // Raster: start plus pitch times line index
    assign raster = 32'(start_i + step * 32'(req_i.line)
        + 32'(req_i.xpos));
    // Sub-picture: column tiles of width bytes, one tile per field height
    assign tile = 32'(pos) >> k;
    assign col = 32'(pos) & ((32'h1 << k) - 32'h1);
    assign stride = 32'(cfg_i.lines) << k;
    assign sub = 32'(start_i + tile * stride
        + (32'(req_i.line) << k) + col);
    // Pitch ignored only for image data in sub-picture mode, not raw
    assign use_sub = cfg_i.subpic && !cfg_i.raw && !req_i.vanc;
    assign addr_o = use_sub ? sub : raster;
endmodule // csa_addr_calc
`default_nettype wire

/* verilog/csa_out_stage.sv */
// One-entry holding stage towards the SDRAM write port
`timescale 1ns/1ns
`default_nettype none
module csa_out_stage #(
    parameter int ADDR_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_ni,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [ADDR_W-1:0] in_addr_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [ADDR_W-1:0] out_addr_o
);
    typedef enum logic {CSA_EMPTY = 1'b0, CSA_FULL = 1'b1} csa_slot_t;
    csa_slot_t state_q;
    csa_slot_t state_d;
    logic [ADDR_W-1:0] addr_q;
    logic take;

    // Width check at elaboration
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_width
        $error("csa_out_stage: ADDR_W out of range");
    end

    // Accept when empty or when the held word leaves this cycle
    assign in_ready_o = (state_q == CSA_EMPTY) || out_ready_i;
    assign take = in_valid_i && in_ready_o;
    assign out_valid_o = (state_q == CSA_FULL);
    assign out_addr_o = addr_q;

    // Next slot state
    always_comb begin
        case (state_q)
            CSA_EMPTY: state_d = take ? CSA_FULL : CSA_EMPTY;
            CSA_FULL: state_d = (out_ready_i && !take) ? CSA_EMPTY : CSA_FULL;
            default: state_d = CSA_EMPTY;
        endcase
    end

    // Slot registers
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            state_q <= CSA_EMPTY;
            addr_q <= '0;
        end else begin
            state_q <= state_d;
            if (take) begin
                addr_q <= in_addr_i;
            end
        end
    end
endmodule // csa_out_stage
`default_nettype wire

/* verilog/csa_top.sv */
// Capture store address block: APB registers and address generation
//
// Summary of operation
// - Holds 8-bit horizontal start byte displacement from area start.
// - Holds 9-bit sub-picture width, used for luma/chroma image data only.
// - Sub-picture width acts only when sub-picture storage is selected.
// - One width serves luma, chroma, both fields; tiles begin at area start.
// - Line offset also steps lines of raw capture data.
// - Raster line address is start plus offset times line; ignored in tiles.
// - Vertical ancillary in muxed mode uses twice the line offset.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module csa_top (
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire csa_pkg::csa_area_t AREA_STARTS_I,
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    input wire csa_pkg::csa_req_t REQ_I,
    output logic WR_VALID_O,
    input wire logic WR_READY_I,
    output logic [31:0] WR_ADDR_O
);
    // Register state
    logic [7:0] hstart_q;
    logic [8:0] width_q;
    logic [31:0] line_ofs_q;
    logic [31:0] ctrl_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // Bus decode
    logic setup_w;
    logic write_w;
    logic hit_cfg;
    logic hit_ofs;
    logic hit_ctrl;
    logic hit_st;
    logic mapped;
    logic [31:0] cfg_view;
    logic [31:0] status_view;
    logic [31:0] rd_mux;

    // Address path
    csa_pkg::csa_cfg_t cfg;
    logic [31:0] sel_start;
    logic [31:0] calc_addr;

    // Setup cycle latches read data, access cycle commits writes
    assign setup_w = PSEL_I && !PENABLE_I;
    assign write_w = PSEL_I && PENABLE_I && PWRITE_I;
    assign hit_cfg = (PADDR_I == csa_pkg::CSA_OFS_SUBPIC_CFG);
    assign hit_ofs = (PADDR_I == csa_pkg::CSA_OFS_LINE_OFS);
    assign hit_ctrl = (PADDR_I == csa_pkg::CSA_OFS_CTRL);
    assign hit_st = (PADDR_I == csa_pkg::CSA_OFS_STATUS);
    assign mapped = hit_cfg || hit_ofs || hit_ctrl || hit_st;

    // Zero-wait slave
    assign PREADY_O = 1'b1;
    assign PRDATA_O = prdata_q;
    assign PSLVERR_O = pslverr_q;

    // Read view of sub-picture config, reserved bits zero
    assign cfg_view = {8'h00, hstart_q, 7'h00, width_q};

    // Live configuration checks shown in status
    assign status_view = {27'h0000000,
        WR_VALID_O,
        (line_ofs_q[csa_pkg::CSA_ALIGN_BITS-1:0] != 3'h0),
        (hstart_q[csa_pkg::CSA_ALIGN_BITS-1:0] != 3'h0),
        ({1'b0, hstart_q} >= width_q),
        !csa_pkg::csa_width_ok(width_q)};

    // Read data selection
    assign rd_mux = hit_cfg ? cfg_view :
        hit_ofs ? line_ofs_q :
        hit_ctrl ? ctrl_q :
        hit_st ? status_view : 32'h0000_0000;

    // Register writes, reserved config bits dropped
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            hstart_q <= csa_pkg::CSA_SUBPIC_RST[23:16];
            width_q <= csa_pkg::CSA_SUBPIC_RST[8:0];
            line_ofs_q <= csa_pkg::CSA_LINE_OFS_RST;
            ctrl_q <= csa_pkg::CSA_CTRL_RST;
        end else if (write_w) begin
            if (hit_cfg) begin
                hstart_q <= PWDATA_I[23:16];
                width_q <= PWDATA_I[8:0];
            end
            if (hit_ofs) begin
                line_ofs_q <= PWDATA_I;
            end
            if (hit_ctrl) begin
                ctrl_q <= PWDATA_I & 32'h0fff_0007;
            end
        end
    end

    // Read answer and error flag held through the access cycle
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_w) begin
            prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !mapped;
        end
    end

    // Configuration bundle for the arithmetic
    assign cfg.subpic = ctrl_q[csa_pkg::CSA_CTRL_SUBPIC];
    assign cfg.raw = ctrl_q[csa_pkg::CSA_CTRL_RAW];
    assign cfg.muxed = ctrl_q[csa_pkg::CSA_CTRL_MUXED];
    assign cfg.hstart = hstart_q;
    assign cfg.width = width_q;
    assign cfg.lines = ctrl_q[27:16];
    assign cfg.line_ofs = line_ofs_q;

    // Area start per field and component, shared width for all four
    assign sel_start = REQ_I.vanc ?
        (REQ_I.bottom ? AREA_STARTS_I.bottom_vanc : AREA_STARTS_I.top_vanc) :
        REQ_I.chroma ?
        (REQ_I.bottom ? AREA_STARTS_I.bottom_chroma :
            AREA_STARTS_I.top_chroma) :
        (REQ_I.bottom ? AREA_STARTS_I.bottom_luma :
            AREA_STARTS_I.top_luma);

    // Address arithmetic
    csa_addr_calc u_calc (
        .cfg_i(cfg),
        .start_i(sel_start),
        .req_i(REQ_I),
        .addr_o(calc_addr)
    );

    // Holding stage towards the SDRAM controller
    csa_out_stage #(
        .ADDR_W(32)
    ) u_out (
        .clk_i(CORE_CLK_I),
        .rst_ni(RESETN_I),
        .in_valid_i(REQ_VALID_I),
        .in_ready_o(REQ_READY_O),
        .in_addr_i(calc_addr),
        .out_valid_o(WR_VALID_O),
        .out_ready_i(WR_READY_I),
        .out_addr_o(WR_ADDR_O)
    );

    // Checks
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    logic req_take;
    logic raster_img;
    logic [31:0] exp_raster;
    logic [31:0] exp_vanc2;
    assign req_take = REQ_VALID_I && REQ_READY_O;
    assign raster_img = !cfg.subpic && !REQ_I.vanc;
    assign exp_raster = 32'(sel_start + line_ofs_q * 32'(REQ_I.line)
        + 32'(REQ_I.xpos));
    assign exp_vanc2 = 32'(sel_start
        + {line_ofs_q[30:0], 1'b0} * 32'(REQ_I.line));

    hstart_store_a: assert property (
        write_w && hit_cfg |=> hstart_q == $past(PWDATA_I[23:16]))
    else $error("horizontal start not stored");

    width_store_a: assert property (
        write_w && hit_cfg |=> width_q == $past(PWDATA_I[8:0]))
    else $error("sub-picture width not stored");

    reserved_zero_a: assert property (
        setup_w && !PWRITE_I && hit_cfg
        |=> PRDATA_O[31:24] == 8'h00 && PRDATA_O[15:9] == 7'h00
            && PRDATA_O[8:0] == $past(width_q))
    else $error("config reserved bits not zero");

    raster_addr_a: assert property (
        req_take && raster_img && !cfg.raw
        |=> WR_VALID_O && WR_ADDR_O == $past(exp_raster))
    else $error("raster line address wrong");

    raw_pitch_a: assert property (
        req_take && cfg.raw && !REQ_I.vanc
        |=> WR_ADDR_O == $past(exp_raster))
    else $error("raw capture ignores line offset");

    vanc_double_a: assert property (
        req_take && REQ_I.vanc && cfg.muxed && REQ_I.xpos == 12'h000
        |=> WR_ADDR_O == $past(exp_vanc2))
    else $error("muxed ancillary pitch not doubled");

    subpic_origin_a: assert property (
        req_take && cfg.subpic && !cfg.raw && !REQ_I.vanc
        && REQ_I.line == 12'h000 && REQ_I.xpos == 12'h000
        && csa_pkg::csa_width_ok(width_q) && {1'b0, hstart_q} < width_q
        |=> WR_ADDR_O == $past(sel_start) + 32'($past(hstart_q)))
    else $error("sub-picture not placed at area start");

    subpic_no_pitch_a: assert property (
        req_take && cfg.subpic && !cfg.raw && !REQ_I.vanc
        |=> WR_VALID_O && WR_ADDR_O == $past(calc_addr))
    else $error("sub-picture address not from tile math");

    hold_stall_a: assert property (
        WR_VALID_O && !WR_READY_I |=> WR_VALID_O && $stable(WR_ADDR_O))
    else $error("write address dropped under stall");

    status_width_a: assert property (
        write_w && hit_cfg && PWDATA_I[8:0] == 9'h011
        |=> status_view[csa_pkg::CSA_ST_WIDTH_BAD])
    else $error("reserved width not flagged");

    zero_wait_a: assert property (
        setup_w && !mapped |=> PSLVERR_O && PREADY_O)
    else $error("unmapped access not refused");

    raster_cov: cover property (req_take && raster_img ##1 WR_VALID_O);
    subpic_cov: cover property (req_take && cfg.subpic && !REQ_I.vanc);
    vanc_cov: cover property (req_take && REQ_I.vanc && cfg.muxed);
    stall_cov: cover property (WR_VALID_O && !WR_READY_I [*3]);
endmodule // csa_top
`default_nettype wire
